// File: rtl/adcssc_regs.svh
// Register offsets, field positions and timing counts of the step control block
`ifndef ADCSSC_REGS_SVH
`define ADCSSC_REGS_SVH
`define ADCSSC_ADDR_W 12
`define ADCSSC_OFF_STEP_CTRL 12'h044
`define ADCSSC_OFF_CTRL 12'h100
`define ADCSSC_OFF_STATUS 12'h104
`define ADCSSC_OFF_IRQ_STAT 12'h108
`define ADCSSC_OFF_IRQ_EN 12'h10c
`define ADCSSC_OFF_IRQ_CLR 12'h110
`define ADCSSC_STEP_CTRL_RESET 32'h00000000
`define ADCSSC_FLD_DIFF 0
`define ADCSSC_FLD_END 1
`define ADCSSC_FLD_IE 2
`define ADCSSC_FLD_TS 3
`define ADCSSC_NIBBLE_W 4
`define ADCSSC_CTRL_START 0
`define ADCSSC_IRQ_SAMPLE 0
`define ADCSSC_IRQ_SEQ_DONE 1
`define ADCSSC_IRQ_W 2
`define ADCSSC_CONV_TIME_NS 1000
`define ADCSSC_CLK_PERIOD_NS 25
`define ADCSSC_CONV_CYCLES ((`ADCSSC_CONV_TIME_NS + `ADCSSC_CLK_PERIOD_NS - 1) / `ADCSSC_CLK_PERIOD_NS)
`endif

// File: rtl/adcssc_pkg.sv
// Types shared by the step control block
package adcssc_pkg;
    typedef enum logic [2:0]
    {
        ADCSSC_IDLE = 3'b001,
        ADCSSC_CONV = 3'b010,
        ADCSSC_NEXT = 3'b100
    } adcssc_state_e;
    typedef logic [2:0] adcssc_step_t;
    typedef struct packed
    {
        logic temp_sel;
        logic irq_en;
        logic last;
        logic diff;
    } adcssc_step_s;
endpackage

// File: rtl/adcssc_step_if.sv
// Per-step field bundle between the register file and the step decoder
`timescale 1ns/1ps
interface adcssc_step_if;
    logic [31:0] word;
    logic [2:0] step;
    logic temp_sel;
    logic irq_en;
    logic last;
    logic diff;
    modport src (output word, output step, input temp_sel, input irq_en, input last, input diff);
    modport dec (input word, input step, output temp_sel, output irq_en, output last, output diff);
endinterface

// File: rtl/adcssc_step_decode.sv
// Picks the four control bits of the current step out of the step control word
`timescale 1ns/1ps
`include "adcssc_regs.svh"
module adcssc_step_decode
    import adcssc_pkg::*;
(
    adcssc_step_if.dec bus
);
    logic [3:0] nib;
    // Nibble of the selected step, lowest nibble is the first step
    assign nib = bus.word[bus.step * `ADCSSC_NIBBLE_W +: `ADCSSC_NIBBLE_W];
    assign bus.temp_sel = nib[`ADCSSC_FLD_TS];
    assign bus.irq_en = nib[`ADCSSC_FLD_IE];
    assign bus.last = nib[`ADCSSC_FLD_END];
    assign bus.diff = nib[`ADCSSC_FLD_DIFF];
endmodule

// File: rtl/adcssc_top.sv
// Step control register and sample sequencer for an eight-step converter sequence
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "adcssc_regs.svh"
module adcssc_top
    import adcssc_pkg::*;
#(
    parameter int CONV_CYCLES = `ADCSSC_CONV_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_conv_start,
    output logic [2:0] o_step,
    output logic o_temp_sel,
    output logic o_diff,
    output logic o_busy,
    output logic o_irq
);
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

    // Register map seen by software:
    // step control word, each nibble one step, lowest nibble first;
    // each nibble holds temperature select, interrupt enable, last marker, differential;
    // control, write-only, bit 0 starts a sequence from the first step;
    // status, read-only, bit 0 busy and bits 3 to 1 the current step;
    // interrupt status, read-only, bit 0 step done, bit 1 sequence done;
    // interrupt enable, same layout as interrupt status;
    // interrupt clear, write-only, a one clears the matching status bit.
    // Timing of one step: the timer runs CONV_CYCLES cycles in the
    // converting state, then one cycle in the next state picks the following
    // step, so steps start CONV_CYCLES plus one cycles apart.
    // The step word is not locked while busy: software should write it
    // only when the busy bit is clear, or the running sequence sees the
    // new fields from its current step on.
    // A sequence with no last marker set runs all eight steps and stops
    // after the top step.
    // Only one set of step fields exists, so a single-entry sequence needs
    // the first step's marker set by software.

    logic [31:0] step_ctrl_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    adcssc_state_e state_reg;
    adcssc_step_t step_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic sample_done;
    logic seq_done;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic start_req;

    adcssc_step_if sbus();

    // Decoder of the current step's fields
    assign sbus.word = step_ctrl_reg;
    assign sbus.step = step_reg;
    adcssc_step_decode u_dec
    (
        .bus(sbus.dec)
    );

    // Start request, a write of the start bit to the control offset
    assign start_req = i_wr && (i_addr == `ADCSSC_OFF_CTRL) && i_wdata[`ADCSSC_CTRL_START];

    // Clear mask, one bit per status flag, only in the write cycle
    assign irq_clr = (i_wr && (i_addr == `ADCSSC_OFF_IRQ_CLR)) ? i_wdata[1:0] : 2'h0;

    // Step control word, fully writable, read back as written
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            step_ctrl_reg <= `ADCSSC_STEP_CTRL_RESET;
        end
        else if (i_wr && (i_addr == `ADCSSC_OFF_STEP_CTRL))
        begin
            // A write while busy takes effect on the step in progress
            step_ctrl_reg <= i_wdata;
        end
    end

    // Interrupt enable, same layout as the status flags
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            irq_en_reg <= 2'h0;
        end
        else if (i_wr && (i_addr == `ADCSSC_OFF_IRQ_EN))
        begin
            irq_en_reg <= i_wdata[1:0];
        end
    end

    // Register reads, data in the cycle after the strobe and zero otherwise
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_rdata <= 32'h00000000;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `ADCSSC_OFF_STEP_CTRL: o_rdata <= step_ctrl_reg;
                `ADCSSC_OFF_STATUS: o_rdata <= {28'h0000000, step_reg, o_busy};
                `ADCSSC_OFF_IRQ_STAT: o_rdata <= {30'h00000000, irq_stat_reg};
                `ADCSSC_OFF_IRQ_EN: o_rdata <= {30'h00000000, irq_en_reg};
                // Control and clear offsets are write-only and read as zero
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
        begin
            // Zero between reads so stale data never lingers on the bus
            o_rdata <= 32'h00000000;
        end
    end

    // A step is done when its conversion time is used up
    assign sample_done = (state_reg == ADCSSC_CONV) && (cnt_reg == CNT_LAST);

    // The sequence ends on the first marked step, or after the top step
    assign seq_done = sample_done && (sbus.last || (step_reg == 3'h7));

    // Sequencer state: idle, converting, stepping to the next entry
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_reg <= ADCSSC_IDLE;
        end
        else
        begin
            case (state_reg)
                ADCSSC_IDLE:
                begin
                    // A start while busy is ignored, only idle looks at it
                    if (start_req)
                        state_reg <= ADCSSC_CONV;
                end
                ADCSSC_CONV:
                begin
                    if (seq_done)
                        state_reg <= ADCSSC_IDLE;
                    else if (sample_done)
                        state_reg <= ADCSSC_NEXT;
                end
                ADCSSC_NEXT:
                begin
                    state_reg <= ADCSSC_CONV;
                end
                default:
                begin
                    // An illegal code falls back to idle
                    state_reg <= ADCSSC_IDLE;
                end
            endcase
        end
    end

    // Step index, restarts at the first step and advances between conversions
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            step_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                ADCSSC_IDLE:
                begin
                    // Held after a sequence so status shows the last converted step
                    if (start_req)
                        step_reg <= 3'h0;
                end
                ADCSSC_NEXT:
                begin
                    step_reg <= step_reg + 3'h1;
                end
                default:
                begin
                    step_reg <= step_reg;
                end
            endcase
        end
    end

    // Conversion timer, counts the cycles of one step's conversion
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ADCSSC_CONV:
                begin
                    // Stops at the last count; the state leaves on that cycle
                    if (!sample_done)
                        cnt_reg <= cnt_reg + 1'b1;
                end
                default:
                begin
                    // Idle and next both prepare a fresh count for the coming step
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // Start pulse to the converter, one cycle at the head of each step
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_conv_start <= 1'b0;
        else
            o_conv_start <= (state_reg == ADCSSC_CONV) && (cnt_reg == '0);
    end

    // Index of the step being converted
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_step <= 3'h0;
        else
            o_step <= step_reg;
    end

    // Temperature sensor select of the current step, aligned with the start pulse
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_temp_sel <= 1'b0;
        else
            o_temp_sel <= sbus.temp_sel;
    end

    // Differential select of the current step, aligned with the start pulse
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_diff <= 1'b0;
        else
            o_diff <= sbus.diff;
    end

    // Busy while the sequencer is out of idle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_busy <= 1'b0;
        else
            o_busy <= (state_reg != ADCSSC_IDLE);
    end

    // Step interrupt when a step with its interrupt enable finishes
    assign irq_set[`ADCSSC_IRQ_SAMPLE] = sample_done && sbus.irq_en;

    // Sequence-done interrupt when the sequencer stops
    assign irq_set[`ADCSSC_IRQ_SEQ_DONE] = seq_done;

    // Sticky interrupt status; a set in the same cycle as its clear wins
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            irq_stat_reg <= 2'h0;
        end
        else
        begin
            // A lost event would be worse than one extra interrupt
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt, built from the next status so it needs no extra cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
        end
    end
endmodule

// File: verification/adcssc_chk.sv
// Port assertions for the step control block
`timescale 1ns/1ps
`include "adcssc_regs.svh"
module adcssc_chk
#(
    parameter int CONV_CYCLES = `ADCSSC_CONV_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_conv_start,
    input wire logic [2:0] o_step,
    input wire logic o_temp_sel,
    input wire logic o_diff,
    input wire logic o_irq
);
    // Cycles from one step's start pulse to the next
    localparam int STEP_LEN = CONV_CYCLES + 1;
    logic [31:0] sc_reg;
    logic en_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Shadow copy of the step word
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            sc_reg <= 32'h0;
        else if (i_wr && i_addr == `ADCSSC_OFF_STEP_CTRL)
            sc_reg <= i_wdata;
    end
    // Shadow copy of the sample interrupt enable
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            en_reg <= 1'b0;
        else if (i_wr && i_addr == `ADCSSC_OFF_IRQ_EN)
            en_reg <= i_wdata[0];
    end
    // No new conversion for eight cycles
    sequence s_quiet;
        !o_conv_start [*8];
    endsequence
    // Start pulse of a step below the top step whose last marker is clear
    sequence s_chain_start;
        o_conv_start && !sc_reg[{o_step, 2'b01}] && (o_step != 3'h7);
    endsequence
    AST_TEMP_SEL: assert property (o_conv_start |-> o_temp_sel == sc_reg[{o_step, 2'b11}])
        else $error("temp select wrong");
    AST_DIFF_SEL: assert property (o_conv_start |-> o_diff == sc_reg[{o_step, 2'b00}])
        else $error("diff select wrong");
    AST_STEP_IRQ: assert property (o_conv_start && sc_reg[{o_step, 2'b10}] && en_reg
        |-> ##[1:STEP_LEN] o_irq)
        else $error("step irq missing");
    AST_LAST_STOP: assert property (o_conv_start && sc_reg[{o_step, 2'b01}] |=> s_quiet)
        else $error("conversion after last step");
    AST_CHAIN: assert property (s_chain_start |-> ##[STEP_LEN:STEP_LEN] o_conv_start)
        else $error("sequence stopped early");
endmodule
bind adcssc_top adcssc_chk #(.CONV_CYCLES(CONV_CYCLES)) adcssc_chk_i (.i_clk(i_clk),
    .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .o_conv_start(o_conv_start), .o_step(o_step),
    .o_temp_sel(o_temp_sel), .o_diff(o_diff), .o_irq(o_irq));

// File: verification/tb.sv
// Random and corner-case bench for the step control block
`timescale 1ns/1ps
`include "adcssc_regs.svh"
module tb;
    logic i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [11:0] i_addr = 12'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, sd = 32'h88527b87, w, v;
    logic [2:0] o_step;
    logic o_conv_start, o_temp_sel, o_diff, o_busy, o_irq, ie;
    logic [7:0] ts_q, df_q;
    int err_total = 0, tests_run = 0, n = 0, base = 0, k, lst;
    adcssc_top #(.CONV_CYCLES(4)) adcssc_top_i (.i_clk(i_clk), .i_srst(i_srst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_conv_start(o_conv_start), .o_step(o_step), .o_temp_sel(o_temp_sel),
        .o_diff(o_diff), .o_busy(o_busy), .o_irq(o_irq));
    initial forever #12.5 i_clk = ~i_clk;
    // Records the fields of each converted step
    always @(posedge i_clk)
        if (o_conv_start === 1'b1)
        begin
            check(o_step, n - base);
            ts_q[o_step] = o_temp_sel;
            df_q[o_step] = o_diff;
            n = n + 1;
        end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // Corner words first, then random words
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(`ADCSSC_OFF_STEP_CTRL);
        check(v, `ADCSSC_STEP_CTRL_RESET);
        rd(12'h0f0);
        check(v, 32'h0);
        wr(`ADCSSC_OFF_IRQ_EN, 32'h3);
        for (int t = 0; t < 12; t++)
        begin
            sd = xs(sd);
            w = (t == 0) ? 32'h2 : (t == 1) ? 32'h0 : (t == 2) ? 32'hffffffff : sd;
            wr(`ADCSSC_OFF_STEP_CTRL, w);
            rd(`ADCSSC_OFF_STEP_CTRL);
            check(v, w);
            lst = 7;
            for (int i = 7; i >= 0; i--)
                if (w[4 * i + 1])
                    lst = i;
            base = n;
            wr(`ADCSSC_OFF_CTRL, 32'h1);
            // A second start while busy must not restart the sequence
            if (t == 1)
                wr(`ADCSSC_OFF_CTRL, 32'h1);
            for (k = 0; k < 200 && !(n > base && o_busy === 1'b0); k++)
                @(negedge i_clk);
            if (k == 200)
            begin
                err_total++;
                break;
            end
            check(n - base, lst + 1);
            rd(`ADCSSC_OFF_STATUS);
            check({v[31:4], v[0]}, 29'h0);
            ie = 1'b0;
            for (int i = 0; i <= lst; i++)
            begin
                check({ts_q[i], df_q[i]}, {w[4 * i + 3], w[4 * i]});
                ie = ie | w[4 * i + 2];
            end
            rd(`ADCSSC_OFF_IRQ_STAT);
            check(v, {30'h0, 1'b1, ie});
            check(o_irq, 1'b1);
            wr(`ADCSSC_OFF_IRQ_CLR, 32'h3);
            repeat (2) @(posedge i_clk);
            check(o_irq, 1'b0);
        end
        end_sim;
    end
endmodule
